/* File: shared/ppoc_pkg.sv */
// package: register map, field positions and reset values of the port block
package ppoc_pkg;
    localparam int PPOC_NPORTS = 8;
    localparam int PPOC_NLOW = 4;
    localparam int PPOC_PW = 8;
    localparam int PPOC_NPINS = PPOC_NPORTS * PPOC_PW;
    localparam int PPOC_NLOWPINS = PPOC_NLOW * PPOC_PW;
    localparam int PPOC_NHIPINS = PPOC_NPINS - PPOC_NLOWPINS;

    // port data latches
    localparam logic [7:0] PORT0_DATA_ADDR = 8'h80;
    localparam logic [7:0] PORT1_DATA_ADDR = 8'h90;
    localparam logic [7:0] PORT2_DATA_ADDR = 8'ha0;
    localparam logic [7:0] PORT3_DATA_ADDR = 8'hb0;
    localparam logic [7:0] PORT4_DATA_ADDR = 8'h84;
    localparam logic [7:0] PORT5_DATA_ADDR = 8'h85;
    localparam logic [7:0] PORT6_DATA_ADDR = 8'h86;
    localparam logic [7:0] PORT7_DATA_ADDR = 8'h96;
    // per-pin output mode of the low ports, then config two and high-port nibble mode
    localparam logic [7:0] PORT0_MODE_ADDR = 8'ha4;
    localparam logic [7:0] PORT1_MODE_ADDR = 8'ha5;
    localparam logic [7:0] PORT2_MODE_ADDR = 8'ha6;
    localparam logic [7:0] PORT3_MODE_ADDR = 8'ha7;
    localparam logic [7:0] MATRIX_CONFIG_REG_TWO_ADDR = 8'he3;
    localparam logic [7:0] HIGH_PORT_NIBBLE_OUTPUT_MODE_ADDR = 8'hb5;

    // fields of matrix_config_reg_two
    localparam int WEAK_PULLUP_DISABLE_BIT = 7;
    localparam int MATRIX_ENABLE_BIT = 6;
    localparam int EXTMEM_LOW_PORT_ENABLE_BIT = 1;

    // reset values
    localparam logic [7:0] PORT_DATA_RST = 8'hff;
    localparam logic [7:0] PORT_MODE_RST = 8'h00;
    localparam logic [7:0] MATRIX_CONFIG_REG_TWO_RST = 8'h00;
    localparam logic [7:0] HIGH_PORT_NIBBLE_OUTPUT_MODE_RST = 8'h00;
    localparam logic [7:0] SFR_UNMAPPED_READ = 8'h00;

    // sfr decode result: register group and port index
    typedef enum logic [2:0] {
        PPOC_SEL_NONE = 3'b000,
        PPOC_SEL_DATA = 3'b001,
        PPOC_SEL_MODE = 3'b010,
        PPOC_SEL_CFG2 = 3'b011,
        PPOC_SEL_HIMODE = 3'b100
    } ppoc_sel_t;
endpackage : ppoc_pkg

/* File: rtl/ppoc_pin_cell.sv */
// one port pin: output driver, pull-up control and input synchroniser
`timescale 1ns/10ps
module ppoc_pin_cell (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // control from the port logic
    input wire logic value_i,
    input wire logic push_pull_i,
    input wire logic drive_en_i,
    input wire logic pullup_dis_i,
    // pad side
    input wire logic pad_i,
    output logic pad_o,
    output logic pad_oe_o,
    output logic pullup_en_o,
    // synchronised pin level
    output logic level_o
);
    logic next_oe;
    logic next_pullup;
    logic sync_q1;

    // push-pull drives both levels, open-drain only the low one
    assign next_oe = drive_en_i & (push_pull_i | ~value_i);
    // never fight our own low drive
    assign next_pullup = ~pullup_dis_i & ~(next_oe & ~value_i);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pad_o <= 1'b0;
            pad_oe_o <= 1'b0;
            pullup_en_o <= 1'b1;
        end else begin
            pad_o <= value_i;
            pad_oe_o <= next_oe;
            pullup_en_o <= next_pullup;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_q1 <= 1'b0;
            level_o <= 1'b0;
        end else begin
            sync_q1 <= pad_i;
            level_o <= sync_q1;
        end
    end
endmodule : ppoc_pin_cell

/* File: rtl/ppoc_port_ctrl.sv */
// port pin output control: data latches, modes, matrix gate, memory takeover
`timescale 1ns/10ps
// Contract
// - unassigned low-port pins are GPIO through the per-port data latches.
// - peripheral sets output of its pins; latch writes do not reach them.
// - ordinary port read returns the actual pin level.
// - read phase of read-modify-write returns latch contents instead.
// - low-port drivers stay off until matrix enable bit (bit 6) is set.
// - pins assigned to peripheral inputs have drivers off.
// - every pin has open-drain or push-pull mode, open-drain at reset.
// - push-pull: zero drives low, one drives high.
// - open-drain: zero drives low, one leaves pin undriven.
// - low ports have a per-pin mode bit, one means push-pull.
// - modes apply always, except two-wire pins and mode-0 UART receive.
// - high ports: one mode bit per nibble, bit 7 is port seven upper.
// - pull-ups on after reset; bit 7 of config two disables all.
// - a pin driving low has its pull-up switched off.
// - off-chip external move drives affected pins, overriding latches.
// - memory activity keeps modes; off-chip reads disable data bus drivers.
// - low-port data registers accept byte and single-bit access.
module ppoc_port_ctrl (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // special function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_bit_wr_i,
    input wire logic [2:0] sfr_bit_idx_i,
    input wire logic sfr_bit_val_i,
    input wire logic sfr_rd_i,
    input wire logic sfr_rmw_i,
    output logic [7:0] sfr_rdata_o,
    // pin assignment matrix, low ports
    input wire logic [ppoc_pkg::PPOC_NLOWPINS-1:0] periph_alloc_i,
    input wire logic [ppoc_pkg::PPOC_NLOWPINS-1:0] periph_out_i,
    input wire logic [ppoc_pkg::PPOC_NLOWPINS-1:0] periph_input_i,
    input wire logic [ppoc_pkg::PPOC_NLOWPINS-1:0] twowire_pin_i,
    input wire logic [ppoc_pkg::PPOC_NLOWPINS-1:0] uart_zero_rx_pin_i,
    input wire logic [ppoc_pkg::PPOC_NLOWPINS-1:0] uart_one_rx_pin_i,
    input wire logic uart_zero_mode0_i,
    input wire logic uart_one_mode0_i,
    // external memory interface on the high ports
    input wire logic extmem_high_i,
    input wire logic extmem_offchip_i,
    input wire logic extmem_read_i,
    input wire logic [ppoc_pkg::PPOC_NHIPINS-1:0] extmem_pin_i,
    input wire logic [ppoc_pkg::PPOC_NHIPINS-1:0] extmem_data_pin_i,
    input wire logic [ppoc_pkg::PPOC_NHIPINS-1:0] extmem_out_i,
    // configuration seen by other blocks
    output logic matrix_enable_o,
    output logic extmem_low_port_enable_o,
    // pads
    input wire logic [ppoc_pkg::PPOC_NPINS-1:0] pad_i,
    output logic [ppoc_pkg::PPOC_NPINS-1:0] pad_o,
    output logic [ppoc_pkg::PPOC_NPINS-1:0] pad_oe_o,
    output logic [ppoc_pkg::PPOC_NPINS-1:0] pullup_en_o
);
    import ppoc_pkg::*;

    // decoding is shared by byte writes, bit writes and reads
    function automatic ppoc_sel_t sfr_group(input logic [7:0] a);
        unique case (a)
            PORT0_DATA_ADDR, PORT1_DATA_ADDR,
            PORT2_DATA_ADDR, PORT3_DATA_ADDR,
            PORT4_DATA_ADDR, PORT5_DATA_ADDR,
            PORT6_DATA_ADDR, PORT7_DATA_ADDR: sfr_group = PPOC_SEL_DATA;
            PORT0_MODE_ADDR, PORT1_MODE_ADDR,
            PORT2_MODE_ADDR, PORT3_MODE_ADDR: sfr_group = PPOC_SEL_MODE;
            MATRIX_CONFIG_REG_TWO_ADDR: sfr_group = PPOC_SEL_CFG2;
            HIGH_PORT_NIBBLE_OUTPUT_MODE_ADDR: sfr_group = PPOC_SEL_HIMODE;
            default: sfr_group = PPOC_SEL_NONE;
        endcase
    endfunction : sfr_group

    function automatic logic [2:0] sfr_port(input logic [7:0] a);
        unique case (a)
            PORT0_DATA_ADDR, PORT0_MODE_ADDR: sfr_port = 3'h0;
            PORT1_DATA_ADDR, PORT1_MODE_ADDR: sfr_port = 3'h1;
            PORT2_DATA_ADDR, PORT2_MODE_ADDR: sfr_port = 3'h2;
            PORT3_DATA_ADDR, PORT3_MODE_ADDR: sfr_port = 3'h3;
            PORT4_DATA_ADDR: sfr_port = 3'h4;
            PORT5_DATA_ADDR: sfr_port = 3'h5;
            PORT6_DATA_ADDR: sfr_port = 3'h6;
            PORT7_DATA_ADDR: sfr_port = 3'h7;
            default: sfr_port = 3'h0;
        endcase
    endfunction : sfr_port

    // bit write merged into a byte, so both paths share one update
    function automatic logic [7:0] bit_merge(
        input logic [7:0] old,
        input logic [2:0] idx,
        input logic val
    );
        logic [7:0] r;
        r = old;
        r[idx] = val;
        bit_merge = r;
    endfunction : bit_merge

    ppoc_sel_t acc_group;
    logic [2:0] acc_port;
    logic acc_any;
    logic [7:0] port_data [PPOC_NPORTS];
    logic [7:0] port_mode [PPOC_NLOW];
    logic [7:0] cfg_two;
    logic [7:0] hi_mode;
    logic [PPOC_NPINS-1:0] pin_level;
    logic [7:0] data_wval [PPOC_NPORTS];
    logic [7:0] mode_wval [PPOC_NLOW];
    logic [7:0] cfg_wval;
    logic [7:0] himode_wval;
    logic [7:0] next_rdata;
    logic [7:0] data_rd;
    logic pullup_dis;
    logic extmem_take;
    logic extmem_rd_off;

    assign acc_any = sfr_wr_i | sfr_bit_wr_i;
    assign acc_group = sfr_group(sfr_addr_i);
    assign acc_port = sfr_port(sfr_addr_i);

    assign matrix_enable_o = cfg_two[MATRIX_ENABLE_BIT];
    assign extmem_low_port_enable_o = cfg_two[EXTMEM_LOW_PORT_ENABLE_BIT];
    assign pullup_dis = cfg_two[WEAK_PULLUP_DISABLE_BIT];
    // memory takeover lasts while the off-chip move executes
    assign extmem_take = extmem_high_i & extmem_offchip_i;
    assign extmem_rd_off = extmem_take & extmem_read_i;

    // port data latches
    genvar p;
    generate
        for (p = 0; p < PPOC_NPORTS; p++) begin : g_data
            // byte or single-bit write to the same latch
            assign data_wval[p] = sfr_bit_wr_i ?
                bit_merge(port_data[p], sfr_bit_idx_i, sfr_bit_val_i) :
                sfr_wdata_i;
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    port_data[p] <= PORT_DATA_RST;
                end else if (acc_any && acc_group == PPOC_SEL_DATA &&
                             acc_port == 3'(p)) begin
                    port_data[p] <= data_wval[p];
                end
            end
        end
    endgenerate

    // low-port per-pin mode registers, open-drain after reset
    generate
        for (p = 0; p < PPOC_NLOW; p++) begin : g_mode
            assign mode_wval[p] = sfr_bit_wr_i ?
                bit_merge(port_mode[p], sfr_bit_idx_i, sfr_bit_val_i) :
                sfr_wdata_i;
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    port_mode[p] <= PORT_MODE_RST;
                end else if (acc_any && acc_group == PPOC_SEL_MODE &&
                             acc_port == 3'(p)) begin
                    port_mode[p] <= mode_wval[p];
                end
            end
        end
    endgenerate

    assign cfg_wval = sfr_bit_wr_i ?
        bit_merge(cfg_two, sfr_bit_idx_i, sfr_bit_val_i) : sfr_wdata_i;
    assign himode_wval = sfr_bit_wr_i ?
        bit_merge(hi_mode, sfr_bit_idx_i, sfr_bit_val_i) : sfr_wdata_i;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_two <= MATRIX_CONFIG_REG_TWO_RST;
        end else if (acc_any && acc_group == PPOC_SEL_CFG2) begin
            cfg_two <= cfg_wval;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hi_mode <= HIGH_PORT_NIBBLE_OUTPUT_MODE_RST;
        end else if (acc_any && acc_group == PPOC_SEL_HIMODE) begin
            hi_mode <= himode_wval;
        end
    end

    // per-pin driver control
    genvar g;
    generate
        for (g = 0; g < PPOC_NPINS; g++) begin : g_pin
            logic value;
            logic push_pull;
            logic drive_en;
            if (g < PPOC_NLOWPINS) begin : g_low
                logic force_od;
                // two-wire and mode-0 receive pins stay open-drain
                assign force_od = twowire_pin_i[g] |
                    (uart_zero_mode0_i & uart_zero_rx_pin_i[g]) |
                    (uart_one_mode0_i & uart_one_rx_pin_i[g]);
                // peripheral owns assigned pins, else the latch
                assign value = periph_alloc_i[g] ? periph_out_i[g] :
                    port_data[g/PPOC_PW][g%PPOC_PW];
                assign push_pull = port_mode[g/PPOC_PW][g%PPOC_PW] &
                    ~force_od;
                // matrix gate and input-assigned pins
                assign drive_en = cfg_two[MATRIX_ENABLE_BIT] &
                    ~(periph_alloc_i[g] & periph_input_i[g]);
            end else begin : g_high
                localparam int H = g - PPOC_NLOWPINS;
                // one mode bit per nibble, port four lower is bit 0
                assign push_pull = hi_mode[H/4];
                assign value = (extmem_take & extmem_pin_i[H]) ?
                    extmem_out_i[H] :
                    port_data[g/PPOC_PW][g%PPOC_PW];
                assign drive_en = ~(extmem_rd_off &
                    extmem_data_pin_i[H]);
            end

            ppoc_pin_cell u_cell (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .value_i(value),
                .push_pull_i(push_pull),
                .drive_en_i(drive_en),
                .pullup_dis_i(pullup_dis),
                .pad_i(pad_i[g]),
                .pad_o(pad_o[g]),
                .pad_oe_o(pad_oe_o[g]),
                .pullup_en_o(pullup_en_o[g]),
                .level_o(pin_level[g])
            );
        end
    endgenerate

    // port read: pin level, or latch during the rmw read phase
    assign data_rd = sfr_rmw_i ? port_data[acc_port] :
        pin_level[acc_port*PPOC_PW +: PPOC_PW];

    always_comb begin
        unique case (acc_group)
            PPOC_SEL_DATA: next_rdata = data_rd;
            PPOC_SEL_MODE: next_rdata = port_mode[acc_port[1:0]];
            PPOC_SEL_CFG2: next_rdata = cfg_two;
            PPOC_SEL_HIMODE: next_rdata = hi_mode;
            default: next_rdata = SFR_UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sfr_rdata_o <= SFR_UNMAPPED_READ;
        end else if (sfr_rd_i) begin
            sfr_rdata_o <= next_rdata;
        end
    end
endmodule : ppoc_port_ctrl

/* File: dv/ppoc_port_ctrl_asserts.sv */
// checker: port-level assertions of the port block
`timescale 1ns/10ps
module ppoc_port_ctrl_asserts import ppoc_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_bit_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_rdata_o,
    // matrix and memory interface
    input wire logic [31:0] periph_alloc_i,
    input wire logic [31:0] periph_input_i,
    input wire logic [31:0] twowire_pin_i,
    input wire logic extmem_high_i,
    input wire logic extmem_offchip_i,
    input wire logic extmem_read_i,
    input wire logic [31:0] extmem_pin_i,
    input wire logic [31:0] extmem_data_pin_i,
    input wire logic [31:0] extmem_out_i,
    // outputs
    input wire logic matrix_enable_o,
    input wire logic extmem_low_port_enable_o,
    input wire logic [63:0] pad_o,
    input wire logic [63:0] pad_oe_o,
    input wire logic [63:0] pullup_en_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic cfgw;
    assign cfgw = sfr_wr_i && !sfr_bit_wr_i && sfr_addr_i == 8'he3;
    drv_gate_a: assert property (!matrix_enable_o &&
        !$past(matrix_enable_o) |-> pad_oe_o[31:0] == '0)
        else $error("low drivers on while matrix off");
    pull_fight_a: assert property (
        (pad_oe_o & ~pad_o & pullup_en_o) == '0)
        else $error("pull-up on a pin driven low");
    pull_off_a: assert property (cfgw && sfr_wdata_i[7]
        |-> ##2 pullup_en_o == '0) else $error("pull-ups not disabled");
    matrix_bit_a: assert property (cfgw |=>
        matrix_enable_o == $past(sfr_wdata_i[6]))
        else $error("matrix enable bit wrong");
    mem_low_bit_a: assert property (cfgw |=>
        extmem_low_port_enable_o == $past(sfr_wdata_i[1]))
        else $error("memory low-port bit wrong");
    unmapped_rd_a: assert property (sfr_rd_i && !(sfr_addr_i inside
        {8'h80, 8'h90, 8'ha0, 8'hb0, 8'h84, 8'h85, 8'h86, 8'h96, 8'ha4,
        8'ha5, 8'ha6, 8'ha7, 8'he3, 8'hb5}) |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    inputs_off_a: assert property ((pad_oe_o[31:0] &
        $past(periph_alloc_i) & $past(periph_input_i)) == '0)
        else $error("peripheral input pin driven");
    od_forced_a: assert property ((pad_oe_o[31:0] & pad_o[31:0] &
        $past(twowire_pin_i)) == '0) else $error("two-wire pin driven high");
    extmem_out_a: assert property ($past(extmem_high_i) &&
        $past(extmem_offchip_i) |->
        ((pad_o[63:32] ^ $past(extmem_out_i)) & $past(extmem_pin_i)) == '0)
        else $error("memory interface value not on pin");
    extmem_rd_a: assert property ($past(extmem_high_i) &&
        $past(extmem_offchip_i) && $past(extmem_read_i) |->
        (pad_oe_o[63:32] & $past(extmem_data_pin_i)) == '0)
        else $error("data bus driven during read");
endmodule : ppoc_port_ctrl_asserts
bind ppoc_port_ctrl ppoc_port_ctrl_asserts i_ppoc_port_ctrl_asserts (.*);

/* File: dv/ppoc_pad_model.sv */
// partner: pins with external drivers, pull-ups and floating lines
`timescale 1ns/10ps
module ppoc_pad_model (
    // clock
    input wire logic clk_i,
    // device side
    input wire logic [63:0] drv_i,
    input wire logic [63:0] oe_i,
    input wire logic [63:0] pu_i,
    // external circuits
    input wire logic [63:0] ext_en_i,
    input wire logic [63:0] ext_val_i,
    output logic [63:0] level_o
);
    logic [63:0] flt = '0;
    // a floating line toggles so a stale level is never read back
    always @(posedge clk_i) flt <= ~flt;
    assign level_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_val_i) |
        (~oe_i & ~ext_en_i & (pu_i | flt));
endmodule : ppoc_pad_model

/* File: dv/ppoc_port_ctrl_tb.sv */
// testbench: register and pin scenarios for the port block
`timescale 1ns/10ps
module ppoc_port_ctrl_tb;
    import ppoc_pkg::*;
    logic clk_i = 0, rstn_i = 0, sfr_wr_i = 0, sfr_bit_wr_i = 0;
    logic sfr_bit_val_i = 0, sfr_rd_i = 0, sfr_rmw_i = 0;
    logic [7:0] sfr_addr_i = '0, sfr_wdata_i = '0, sfr_rdata_o;
    logic [2:0] sfr_bit_idx_i = '0;
    logic [31:0] periph_alloc_i = '0, periph_out_i = '0, periph_input_i = '0;
    logic [31:0] twowire_pin_i = '0, uart_zero_rx_pin_i = '0;
    logic [31:0] uart_one_rx_pin_i = '0, extmem_pin_i = '0;
    logic [31:0] extmem_data_pin_i = '0, extmem_out_i = '0;
    logic uart_zero_mode0_i = 0, uart_one_mode0_i = 0, extmem_high_i = 0;
    logic extmem_offchip_i = 0, extmem_read_i = 0;
    logic matrix_enable_o, extmem_low_port_enable_o;
    logic [63:0] pad_i, pad_o, pad_oe_o, pullup_en_o, ext_en = '0;
    int mismatches = 0, n_checks = 0, cyc = 0;
    ppoc_port_ctrl i_ppoc_port_ctrl (.*);
    ppoc_pad_model i_ppoc_pad_model (.clk_i(clk_i), .drv_i(pad_o),
        .oe_i(pad_oe_o), .pu_i(pullup_en_o), .ext_en_i(ext_en),
        .ext_val_i(64'h0), .level_o(pad_i));
    always #2.5 clk_i = ~clk_i;
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // k: 0 byte write, 1 bit write (d = value, index), 2 read, 3 rmw read
    task automatic acc(input logic [7:0] a, input logic [1:0] k,
        input logic [7:0] d);
        @(posedge clk_i);
        sfr_addr_i <= a;
        sfr_wdata_i <= d;
        sfr_bit_idx_i <= d[2:0];
        sfr_bit_val_i <= d[3];
        sfr_wr_i <= (k == 2'd0);
        sfr_bit_wr_i <= (k == 2'd1);
        sfr_rd_i <= k[1];
        sfr_rmw_i <= (k == 2'd3);
        @(posedge clk_i);
        sfr_wr_i <= 1'b0;
        sfr_bit_wr_i <= 1'b0;
        sfr_rd_i <= 1'b0;
        sfr_rmw_i <= 1'b0;
    endtask : acc
    task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] e);
        acc(a, {1'b1, m}, 8'h00);
        #1;
        chk(sfr_rdata_o, e);
    endtask : rd
    task automatic st(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : st
    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        st(1);
        chk(pullup_en_o, '1);
        chk(pad_oe_o, '0);
        rd(8'hb5, 0, 8'h00);
        rd(8'ha4, 0, 8'h00);
        acc(8'h80, 0, 8'h00);
        st(2);
        chk(pad_oe_o[31:0], '0);
        rd(8'h80, 1, 8'h00);
        rd(8'h80, 0, 8'hff);
        acc(8'he3, 0, 8'h40);
        st(1);
        chk(matrix_enable_o, 1);
        chk(pad_oe_o[7:0], 8'hff);
        chk(pullup_en_o[7:0], 8'h00);
        acc(8'ha4, 0, 8'h0f);
        acc(8'h80, 0, 8'h05);
        acc(8'h80, 1, 8'h09);
        st(1);
        chk(pad_o[7:0], 8'h07);
        chk(pullup_en_o[7:0], 8'h07);
        acc(8'h80, 0, 8'hf0);
        ext_en <= 64'h20;
        st(1);
        // two sync stages: this read still shows the old pin levels
        rd(8'h80, 0, 8'h07);
        chk(pad_oe_o[7:0], 8'h0f);
        rd(8'h80, 0, 8'hd0);
        rd(8'h80, 1, 8'hf0);
        @(posedge clk_i);
        periph_alloc_i <= 32'h6;
        periph_out_i <= 32'h2;
        periph_input_i <= 32'h4;
        acc(8'h80, 0, 8'h00);
        st(1);
        chk(pad_oe_o[7:0], 8'hfb);
        chk(pad_o[7:0], 8'h02);
        @(posedge clk_i);
        periph_alloc_i <= '0;
        twowire_pin_i <= 32'h1;
        uart_zero_rx_pin_i <= 32'h8;
        uart_zero_mode0_i <= 1'b1;
        acc(8'h80, 0, 8'h09);
        st(1);
        chk(pad_oe_o[7:0], 8'hf6);
        @(posedge clk_i);
        uart_zero_mode0_i <= 1'b0;
        uart_one_rx_pin_i <= 32'h8;
        st(2);
        chk(pad_oe_o[7:0], 8'hfe);
        @(posedge clk_i);
        uart_one_mode0_i <= 1'b1;
        st(2);
        chk(pad_oe_o[7:0], 8'hf6);
        acc(8'he3, 0, 8'hc2);
        st(1);
        chk(pullup_en_o, '0);
        chk(extmem_low_port_enable_o, 1);
        rd(8'he3, 0, 8'hc2);
        acc(8'hb5, 0, 8'h80);
        acc(8'h96, 0, 8'ha5);
        st(1);
        chk(pad_oe_o[63:56], 8'hfa);
        rd(8'hb5, 0, 8'h80);
        @(posedge clk_i);
        extmem_high_i <= 1'b1;
        extmem_offchip_i <= 1'b1;
        extmem_pin_i <= 32'hff000000;
        extmem_out_i <= 32'h3c000000;
        st(2);
        chk(pad_o[63:56], 8'h3c);
        chk(pad_oe_o[63:56], 8'hf3);
        @(posedge clk_i);
        extmem_read_i <= 1'b1;
        extmem_data_pin_i <= 32'h0f000000;
        st(2);
        chk(pad_oe_o[63:56], 8'hf0);
        @(posedge clk_i);
        extmem_offchip_i <= 1'b0;
        st(2);
        chk(pad_o[63:56], 8'ha5);
        acc(8'h01, 0, 8'h5a);
        rd(8'h01, 0, 8'h00);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        st(2);
        chk(pad_oe_o, '0);
        @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(8'hb5, 0, 8'h00);
        rd(8'h96, 1, 8'hff);
        end_of_test();
    end
endmodule : ppoc_port_ctrl_tb
